// ---- fcd_fuse_config_decode.v ----
// Purpose: decode start-up, section and lock fuses behind APB
// Assumes: fuse pins are static; erase request is on CORE_CLK
// Notes:   fuse fields take effect when the start-up delay ends
`timescale 1ns/10ps
`default_nettype none
`include "fcd_regs.vh"

module fcd_fuse_config_decode #(
    parameter MS_CYCLES = `FCD_MS_CYCLES
) (
    // clock and reset
    input  wire        CORE_CLK,
    input  wire        RST_N,
    // apb slave
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [9:0]  PADDR,
    input  wire [31:0] PWDATA,
    output wire [31:0] PRDATA,
    output wire        PREADY,
    output wire        PSLVERR,
    // fuse array pins
    input  wire [2:0]  FUSE_STARTUP_DELAY_SEL,
    input  wire [7:0]  FUSE_APP_SECTION_END,
    input  wire [7:0]  FUSE_BOOT_SECTION_END,
    input  wire [7:0]  FUSE_LOCK_CODE,
    input  wire        FUSE_EEPROM_KEEP_ON_ERASE,
    // chip erase
    input  wire        CHIP_ERASE_REQ,
    output wire        EEPROM_ERASE,
    // decoded state
    output wire        STARTUP_DONE,
    output wire        DEVICE_OPEN,
    output wire [15:0] BOOT_END_ADDR,
    output wire [15:0] APP_END_ADDR
);

    ////////////////////////////////////////////////////////////////////
    // state machine codes and decode selects
    localparam [1:0] ST_SYNC  = 2'h0;   // fuse synchronisers filling
    localparam [1:0] ST_DELAY = 2'h1;   // start-up delay running
    localparam [1:0] ST_RUN   = 2'h2;   // fuses in effect

    localparam [2:0] SEL_NONE  = 3'h0;  // unmapped
    localparam [2:0] SEL_SUT   = 3'h1;  // start-up delay config
    localparam [2:0] SEL_APP   = 3'h2;  // application section end
    localparam [2:0] SEL_BOOT  = 3'h3;  // boot section end
    localparam [2:0] SEL_LOCK  = 3'h4;  // lock code
    localparam [2:0] SEL_STAT  = 3'h5;  // status
    localparam [2:0] SEL_QUERY = 3'h6;  // section query

    ////////////////////////////////////////////////////////////////////
    // declarations
    reg  [27:0] sync1_q;                // first sync stage
    reg  [27:0] sync2_q;                // second sync stage
    wire [27:0] fuse_raw;               // packed fuse pins
    wire [2:0]  f_sut;                  // synced start-up code
    wire [7:0]  f_app;                  // synced app end
    wire [7:0]  f_boot;                 // synced boot end
    wire [7:0]  f_lock;                 // synced lock code
    wire        f_keep;                 // synced eeprom keep
    reg  [1:0]  state_q;                // start-up state
    reg  [1:0]  state_d;
    reg  [1:0]  wait_q;                 // sync settle counter
    reg         start_q;                // timer start pulse
    reg         start_d;
    wire        delay_done;             // timer finished
    reg  [2:0]  sut_q;                  // live start-up code
    reg  [7:0]  app_q;                  // live app end
    reg  [7:0]  boot_q;                 // live boot end
    reg  [7:0]  lock_q;                 // live lock code
    reg  [7:0]  lock_d;
    reg         keep_q;                 // live eeprom keep
    reg         done_q;                 // fuses loaded
    reg         open_q;                 // device open
    reg         ee_erase_q;             // eeprom erase pulse
    reg  [15:0] qaddr_q;                // query address
    reg  [1:0]  qsec_q;                 // query answer
    wire [1:0]  qsec;                   // classifier output
    reg  [31:0] prdata_q;               // read data
    reg         err_q;                  // error for current access
    reg  [31:0] rd_mux;                 // read mux
    wire [2:0]  sel_now;                // decoded select
    wire        setup_ph;               // apb setup cycle
    wire        wr_acc;                 // apb write access phase
    wire        load;                   // fuse load moment

    ////////////////////////////////////////////////////////////////////
    // address decode shared by reads and writes
    function [2:0] reg_sel;
        input [9:0] a;
        begin
            if (a == `FCD_ADDR_STARTUP) begin
                reg_sel = SEL_SUT;
            end else if (a == `FCD_ADDR_APP_END) begin
                reg_sel = SEL_APP;
            end else if (a == `FCD_ADDR_BOOT_END) begin
                reg_sel = SEL_BOOT;
            end else if (a == `FCD_ADDR_LOCK) begin
                reg_sel = SEL_LOCK;
            end else if (a == `FCD_ADDR_STATUS) begin
                reg_sel = SEL_STAT;
            end else if (a == `FCD_ADDR_QUERY) begin
                reg_sel = SEL_QUERY;
            end else begin
                reg_sel = SEL_NONE;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // two-flop synchronisers for the fuse pins
    assign fuse_raw = {FUSE_EEPROM_KEEP_ON_ERASE, FUSE_LOCK_CODE,
                       FUSE_BOOT_SECTION_END, FUSE_APP_SECTION_END,
                       FUSE_STARTUP_DELAY_SEL};

    always @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            sync1_q <= 28'h0000000;
            sync2_q <= 28'h0000000;
        end else begin
            sync1_q <= fuse_raw;
            sync2_q <= sync1_q;
        end
    end

    // unpack second stage only
    assign f_sut  = sync2_q[2:0];
    assign f_app  = sync2_q[10:3];
    assign f_boot = sync2_q[18:11];
    assign f_lock = sync2_q[26:19];
    assign f_keep = sync2_q[27];

    ////////////////////////////////////////////////////////////////////
    // start-up sequence: settle, delay, then load
    always @* begin
        state_d = state_q;
        start_d = 1'b0;
        case (state_q)
            ST_SYNC: begin
                // wait until synced fuse values are valid
                if (wait_q == `FCD_SYNC_WAIT) begin
                    state_d = ST_DELAY;
                    start_d = 1'b1;
                end
            end
            ST_DELAY: begin
                // delay chosen by the fuse code
                if (delay_done && !start_q) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                state_d = ST_RUN;
            end
            default: begin
                state_d = ST_SYNC;
            end
        endcase
    end

    // state and settle counter
    always @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= ST_SYNC;
            wait_q  <= 2'h0;
            start_q <= 1'b0;
        end else begin
            state_q <= state_d;
            start_q <= start_d;
            if (state_q == ST_SYNC && wait_q != `FCD_SYNC_WAIT) begin
                wait_q <= wait_q + 2'h1;
            end
        end
    end

    // fuses take effect when the delay ends
    assign load = (state_q == ST_DELAY) && (state_d == ST_RUN);

    fcd_startup_timer #(
        .MS_CYCLES (MS_CYCLES)
    ) u_timer (
        .clk   (CORE_CLK),
        .rst_n (RST_N),
        .start (start_q),
        .sel   (f_sut),
        .done  (delay_done)
    );

    ////////////////////////////////////////////////////////////////////
    // apb handshake
    assign setup_ph = PSEL && !PENABLE;
    assign wr_acc   = PSEL && PENABLE && PWRITE;
    assign sel_now  = reg_sel(PADDR);
    assign PREADY   = 1'b1;
    assign PSLVERR  = PSEL && PENABLE && err_q;
    assign PRDATA   = prdata_q;

    // lock code next value: fuse load or software write
    always @* begin
        lock_d = lock_q;
        if (load) begin
            lock_d = f_lock;
        end else if (wr_acc && sel_now == SEL_LOCK && done_q) begin
            lock_d = PWDATA[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // live configuration fields
    always @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            sut_q  <= 3'h0;
            app_q  <= `FCD_RST_BYTE;
            boot_q <= `FCD_RST_BYTE;
            lock_q <= `FCD_RST_BYTE;
            keep_q <= 1'b0;
            done_q <= 1'b0;
            open_q <= 1'b0;
        end else begin
            if (load) begin
                // copy fuse values at end of start-up
                sut_q  <= f_sut;
                app_q  <= f_app;
                boot_q <= f_boot;
                keep_q <= f_keep;
                done_q <= 1'b1;
            end
            lock_q <= lock_d;
            // only the exact open code unlocks
            open_q <= (lock_d == `FCD_OPEN_CODE);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // chip erase: eeprom spared before start-up ends or when open and keep set
    always @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ee_erase_q <= 1'b0;
        end else begin
            ee_erase_q <= CHIP_ERASE_REQ && done_q && (!open_q || !keep_q);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // section query: classify a written address
    fcd_section_map u_map (
        .boot_end (boot_q),
        .app_end  (app_q),
        .addr     (qaddr_q),
        .section  (qsec)
    );

    always @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            qaddr_q <= `FCD_RST_ADDR;
            qsec_q  <= `FCD_SEC_APP;
        end else begin
            if (wr_acc && sel_now == SEL_QUERY) begin
                qaddr_q <= PWDATA[15:0];
            end
            qsec_q <= qsec;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read mux; upper bits read zero
    always @* begin
        rd_mux = 32'h00000000;
        if (sel_now == SEL_SUT) begin
            rd_mux[`FCD_SUT_MSB:0] = sut_q;
        end else if (sel_now == SEL_APP) begin
            rd_mux[7:0] = app_q;
        end else if (sel_now == SEL_BOOT) begin
            rd_mux[7:0] = boot_q;
        end else if (sel_now == SEL_LOCK) begin
            rd_mux[7:0] = lock_q;
        end else if (sel_now == SEL_STAT) begin
            rd_mux[`FCD_ST_DONE_BIT] = done_q;
            rd_mux[`FCD_ST_OPEN_BIT] = open_q;
            rd_mux[`FCD_ST_KEEP_BIT] = keep_q;
        end else if (sel_now == SEL_QUERY) begin
            rd_mux[15:0] = qaddr_q;
            rd_mux[`FCD_Q_SEC_MSB:`FCD_Q_SEC_LSB] = qsec_q;
        end
    end

    // read data and error captured in the setup cycle
    always @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            prdata_q <= 32'h00000000;
            err_q    <= 1'b0;
        end else if (setup_ph) begin
            err_q <= (sel_now == SEL_NONE);
            if (PWRITE) begin
                prdata_q <= 32'h00000000;
            end else begin
                prdata_q <= rd_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // decoded outputs
    assign STARTUP_DONE  = done_q;
    assign DEVICE_OPEN   = open_q;
    assign EEPROM_ERASE  = ee_erase_q;
    assign BOOT_END_ADDR = {boot_q, 8'h00};
    assign APP_END_ADDR  = {app_q, 8'h00};

endmodule
`default_nettype wire

// ---- fcd_regs.vh ----
// Purpose: constants of the fuse configuration decoder
// Assumes: register index times four gives the APB byte address
// Notes:   definitions only, guarded against double inclusion
`ifndef FCD_REGS_VH
`define FCD_REGS_VH

////////////////////////////////////////////////////////////////////////
// register indexes (byte address is index times four)
`define FCD_IDX_STARTUP     8'h06
`define FCD_IDX_APP_END     8'h07
`define FCD_IDX_BOOT_END    8'h08
`define FCD_IDX_LOCK        8'h0a
`define FCD_IDX_STATUS      8'h0c
`define FCD_IDX_QUERY       8'h0d

// byte addresses on the 10-bit apb address
`define FCD_ADDR_STARTUP    {`FCD_IDX_STARTUP, 2'b00}
`define FCD_ADDR_APP_END    {`FCD_IDX_APP_END, 2'b00}
`define FCD_ADDR_BOOT_END   {`FCD_IDX_BOOT_END, 2'b00}
`define FCD_ADDR_LOCK       {`FCD_IDX_LOCK, 2'b00}
`define FCD_ADDR_STATUS     {`FCD_IDX_STATUS, 2'b00}
`define FCD_ADDR_QUERY      {`FCD_IDX_QUERY, 2'b00}

////////////////////////////////////////////////////////////////////////
// field positions
`define FCD_SUT_MSB         2
`define FCD_ST_DONE_BIT     0
`define FCD_ST_OPEN_BIT     1
`define FCD_ST_KEEP_BIT     2
`define FCD_Q_SEC_LSB       16
`define FCD_Q_SEC_MSB       17

// reset values and codes
`define FCD_RST_BYTE        8'h00
`define FCD_RST_ADDR        16'h0000
`define FCD_OPEN_CODE       8'hc5
`define FCD_SEC_BOOT        2'h0
`define FCD_SEC_APP         2'h1
`define FCD_SEC_DATA        2'h2

////////////////////////////////////////////////////////////////////////
// timing
`define FCD_CLK_PERIOD_NS   100
`define FCD_MS_NS           1000000
`define FCD_MS_CYCLES       ((`FCD_MS_NS + `FCD_CLK_PERIOD_NS - 1) / `FCD_CLK_PERIOD_NS)
`define FCD_SYNC_WAIT       2'h3

`endif

// ---- fcd_startup_timer.v ----
// Purpose: power-up delay of 0 to 64 ms chosen by a 3-bit code
// Assumes: start is a one-cycle pulse, sel is stable while running
// Notes:   done stays high until reset or a start with a nonzero code
`timescale 1ns/10ps
`default_nettype none
`include "fcd_regs.vh"

module fcd_startup_timer #(
    parameter MS_CYCLES = `FCD_MS_CYCLES
) (
    // clock and reset
    input  wire       clk,
    input  wire       rst_n,
    // control
    input  wire       start,
    input  wire [2:0] sel,
    output reg        done
);

    localparam integer PRE_LAST_I = MS_CYCLES - 1;  // last prescaler count, full width
    localparam [23:0] PRE_LAST = PRE_LAST_I[23:0];  // cut to the prescaler width

    reg  [23:0] pre_q;                            // cycles within a ms
    reg  [6:0]  ms_q;                             // whole ms elapsed
    reg         run_q;                            // delay running
    wire [6:0]  target;                           // ms wanted

    // code 0 is no delay, code n is 2^(n-1) ms
    function [6:0] ms_target;
        input [2:0] s;
        begin
            if (s == 3'h0) begin
                ms_target = 7'h00;
            end else begin
                ms_target = 7'h01 << (s - 3'h1);
            end
        end
    endfunction

    assign target = ms_target(sel);

    // prescaler and ms counter
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_q <= 24'h000000;
            ms_q  <= 7'h00;
            run_q <= 1'b0;
            done  <= 1'b0;
        end else if (start) begin
            pre_q <= 24'h000000;
            ms_q  <= 7'h00;
            run_q <= (target != 7'h00);
            done  <= (target == 7'h00);
        end else if (run_q) begin
            if (pre_q == PRE_LAST) begin
                pre_q <= 24'h000000;
                ms_q  <= ms_q + 7'h01;
                // finished on the last whole ms
                if (ms_q + 7'h01 == target) begin
                    run_q <= 1'b0;
                    done  <= 1'b1;
                end
            end else begin
                pre_q <= pre_q + 24'h000001;
            end
        end
    end

endmodule
`default_nettype wire

// ---- fcd_section_map.v ----
// Purpose: classify a flash address as boot, app code or app data
// Assumes: end values are in 256-byte blocks
// Notes:   purely combinational
`timescale 1ns/10ps
`default_nettype none
`include "fcd_regs.vh"

module fcd_section_map (
    // section ends in blocks
    input  wire [7:0]  boot_end,
    input  wire [7:0]  app_end,
    // address to classify
    input  wire [15:0] addr,
    output reg  [1:0]  section
);

    wire [15:0] boot_lim = {boot_end, 8'h00};  // boot end in bytes
    wire [15:0] app_lim  = {app_end, 8'h00};   // app end in bytes

    // boot zero cases, boot compare, then app zero case, app compare
    always @* begin
        if (app_end == 8'h00 && boot_end == 8'h00) begin
            section = `FCD_SEC_APP;
        end else if (boot_end == 8'h00) begin
            section = `FCD_SEC_BOOT;
        end else if (addr < boot_lim) begin
            section = `FCD_SEC_BOOT;
        end else if (app_end == 8'h00) begin
            section = `FCD_SEC_APP;
        end else if (addr < app_lim) begin
            section = `FCD_SEC_APP;
        end else begin
            section = `FCD_SEC_DATA;
        end
    end

endmodule
`default_nettype wire

// ---- fcd_fuse_config_decode_properties.sv ----
// Purpose: port-level checks of the fuse configuration decoder
// Assumes: fuse pins are stable from reset release
// Notes:   bound onto the top module after the checker
`timescale 1ns/10ps
`default_nettype none

module fcd_props #(
    parameter MS_CYCLES = 4
) (
    // clock and reset
    input wire logic        CORE_CLK,
    input wire logic        RST_N,
    // apb request
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [9:0]  PADDR,
    input wire logic [31:0] PWDATA,
    // fuse pins
    input wire logic [2:0]  FUSE_STARTUP_DELAY_SEL,
    input wire logic [7:0]  FUSE_APP_SECTION_END,
    input wire logic [7:0]  FUSE_BOOT_SECTION_END,
    input wire logic [7:0]  FUSE_LOCK_CODE,
    input wire logic        FUSE_EEPROM_KEEP_ON_ERASE,
    // erase and decoded state
    input wire logic        CHIP_ERASE_REQ,
    input wire logic        EEPROM_ERASE,
    input wire logic        STARTUP_DONE,
    input wire logic        DEVICE_OPEN,
    input wire logic [15:0] BOOT_END_ADDR,
    input wire logic [15:0] APP_END_ADDR
);
    ////////////////////////////////////////////////////////////////////////
    logic [15:0] cnt_q;                               // cycles since reset release
    wire  [15:0] dly = (FUSE_STARTUP_DELAY_SEL == 3'h0) ? 16'h0000 :
                       (16'(MS_CYCLES) << (FUSE_STARTUP_DELAY_SEL - 3'h1));
    wire         wr_open = (PWDATA[7:0] == 8'hc5);   // written code opens

    // saturating cycle counter, cleared by reset
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) cnt_q <= 16'h0000;
        else if (cnt_q != 16'hffff) cnt_q <= cnt_q + 16'h0001;
    end

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    // erase request cases and lock write
    sequence erase_locked_s; CHIP_ERASE_REQ && STARTUP_DONE && !DEVICE_OPEN; endsequence
    sequence erase_kept_s; CHIP_ERASE_REQ && STARTUP_DONE && DEVICE_OPEN && FUSE_EEPROM_KEEP_ON_ERASE; endsequence
    sequence lock_wr_s; PSEL && PENABLE && PWRITE && PADDR == 10'h028 && STARTUP_DONE; endsequence

    ////////////////////////////////////////////////////////////////////////
    startup_time_a: assert property ($rose(STARTUP_DONE) |-> cnt_q >= dly && cnt_q <= dly + 16'd12)
        else $error("start-up delay length wrong");
    app_addr_a: assert property (STARTUP_DONE |-> APP_END_ADDR == {FUSE_APP_SECTION_END, 8'h00})
        else $error("app end address wrong");
    boot_addr_a: assert property (STARTUP_DONE |-> BOOT_END_ADDR == {FUSE_BOOT_SECTION_END, 8'h00})
        else $error("boot end address wrong");
    open_load_a: assert property ($rose(STARTUP_DONE) |=> DEVICE_OPEN == (FUSE_LOCK_CODE == 8'hc5))
        else $error("open state after load wrong");
    lock_write_a: assert property (lock_wr_s |=> DEVICE_OPEN == $past(wr_open))
        else $error("open state after lock write wrong");
    locked_early_a: assert property (!STARTUP_DONE |-> !DEVICE_OPEN)
        else $error("open before load");
    done_hold_a: assert property (STARTUP_DONE |=> STARTUP_DONE)
        else $error("start-up done dropped");
    erase_locked_a: assert property (erase_locked_s |=> EEPROM_ERASE)
        else $error("locked erase spared eeprom");
    erase_kept_a: assert property (erase_kept_s |=> !EEPROM_ERASE)
        else $error("kept eeprom erased");
    erase_cause_a: assert property (EEPROM_ERASE |-> $past(CHIP_ERASE_REQ) && $past(STARTUP_DONE))
        else $error("eeprom erase without request");
endmodule

bind fcd_fuse_config_decode fcd_props #(.MS_CYCLES(MS_CYCLES)) fcd_props_i (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .FUSE_STARTUP_DELAY_SEL(FUSE_STARTUP_DELAY_SEL),
    .FUSE_APP_SECTION_END(FUSE_APP_SECTION_END), .FUSE_BOOT_SECTION_END(FUSE_BOOT_SECTION_END),
    .FUSE_LOCK_CODE(FUSE_LOCK_CODE), .FUSE_EEPROM_KEEP_ON_ERASE(FUSE_EEPROM_KEEP_ON_ERASE),
    .CHIP_ERASE_REQ(CHIP_ERASE_REQ), .EEPROM_ERASE(EEPROM_ERASE), .STARTUP_DONE(STARTUP_DONE),
    .DEVICE_OPEN(DEVICE_OPEN), .BOOT_END_ADDR(BOOT_END_ADDR), .APP_END_ADDR(APP_END_ADDR));
`default_nettype wire

// ---- tb_top.sv ----
// Purpose: self-checking bench of the fuse configuration decoder
// Assumes: millisecond shortened to 4 cycles
// Notes:   one reset per fuse set, random fuses from a fixed seed
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    localparam int MSC = 4;                    // cycles per shortened ms
    logic        clk, rst_n;                   // clock and reset
    logic        psel, penable, pwrite;        // apb request
    logic [9:0]  paddr;
    logic [31:0] pwdata, rd;                   // write data, last read
    wire  [31:0] prdata;
    wire         pready, pslverr, ee_erase, done, open_w;
    logic [2:0]  f_sut;                        // fuse levels
    logic [7:0]  f_app, f_boot, f_lock, v;
    logic [7:0]  nb, na, nl;                   // next fuse set
    logic        f_keep, erase_req, er, nk;
    wire  [15:0] boot_addr, app_addr;
    logic [15:0] qa [5];                       // query addresses
    int          n_fail, compares, seed, cyc, i, j, k, dly;

    fcd_fuse_config_decode #(.MS_CYCLES(MSC)) fcd_fuse_config_decode_i (
        .CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .FUSE_STARTUP_DELAY_SEL(f_sut), .FUSE_APP_SECTION_END(f_app), .FUSE_BOOT_SECTION_END(f_boot),
        .FUSE_LOCK_CODE(f_lock), .FUSE_EEPROM_KEEP_ON_ERASE(f_keep), .CHIP_ERASE_REQ(erase_req),
        .EEPROM_ERASE(ee_erase), .STARTUP_DONE(done), .DEVICE_OPEN(open_w),
        .BOOT_END_ADDR(boot_addr), .APP_END_ADDR(app_addr));

    ////////////////////////////////////////////////////////////////////////
    // compare and count
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // one-cycle erase pulse, answer looked at one cycle later
    task automatic erase(input logic e);
        @(posedge clk);
        erase_req <= 1'b1;
        @(posedge clk);
        erase_req <= 1'b0;
        @(posedge clk);
        chk({31'h0, ee_erase}, {31'h0, e});
    endtask

    // expected class of a flash address
    function automatic logic [1:0] sec(input logic [7:0] b, a, input logic [15:0] ad);
        if (b == 8'h00 && a == 8'h00) return 2'h1;
        if (b == 8'h00) return 2'h0;
        if (ad < {b, 8'h00}) return 2'h0;
        if (a == 8'h00) return 2'h1;
        if (ad < {a, 8'h00}) return 2'h1;
        return 2'h2;
    endfunction

    task automatic final_report;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            n_fail++;
            final_report;
        end
    end

    // main sequence, one fuse set per start-up code
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata, erase_req} = '0;
        {f_sut, f_app, f_boot, f_lock, f_keep} = '0;
        seed = 64838;
        for (i = 0; i < 8; i++) begin
            nb = 8'($random(seed));
            na = nb + 8'($random(seed) & 32'h3f);
            if (na < nb) na = 8'hff;
            if (i == 1) {nb, na} = 16'h0000;
            if (i == 2) nb = 8'h00;
            if (i == 3) na = 8'h00;
            nl = (i % 3 == 0) ? 8'hc5 : 8'($random(seed));
            nk = (i == 6) ? 1'b1 : 1'($random(seed));
            // fuses only change together with the reset edge
            @(posedge clk);
            rst_n <= 1'b0;
            {f_sut, f_app, f_boot, f_lock, f_keep} <= {i[2:0], na, nb, nl, nk};
            repeat (2) @(posedge clk);
            rst_n <= 1'b1;
            k = 0;
            if (i >= 3) begin
                apb(1'b1, 10'h028, 32'hc5);
                erase(1'b0);
                k = 6;
            end
            while (done !== 1'b1 && k < 2000) begin
                @(posedge clk);
                k++;
            end
            dly = (i == 0) ? 0 : (MSC << (i - 1));
            chk({31'h0, k >= dly && k <= dly + 12}, 32'h1);
            chk({16'h0, boot_addr}, {16'h0, f_boot, 8'h00});
            chk({16'h0, app_addr}, {16'h0, f_app, 8'h00});
            @(posedge clk);
            chk({31'h0, open_w}, {31'h0, f_lock == 8'hc5});
            apb(1'b1, 10'h018, 32'hffffffff);
            apb(1'b0, 10'h018, 32'h0);
            chk(rd, {29'h0, i[2:0]});
            apb(1'b0, 10'h01c, 32'h0);
            chk(rd, {24'h0, f_app});
            apb(1'b0, 10'h020, 32'h0);
            chk(rd, {24'h0, f_boot});
            apb(1'b0, 10'h028, 32'h0);
            chk(rd, {24'h0, f_lock});
            apb(1'b0, 10'h030, 32'h0);
            chk(rd, {29'h0, f_keep, f_lock == 8'hc5, 1'b1});
            apb(1'b0, 10'h024, 32'h0);
            chk(rd, 32'h0);
            chk({31'h0, er}, 32'h1);
            qa = '{{f_boot, 8'h00} - 16'h1, {f_boot, 8'h00}, {f_app, 8'h00} - 16'h1,
                   {f_app, 8'h00}, 16'($random(seed))};
            for (j = 0; j < 5; j++) begin
                apb(1'b1, 10'h034, {16'h0, qa[j]});
                apb(1'b0, 10'h034, 32'h0);
                chk({30'h0, rd[17:16]}, {30'h0, sec(f_boot, f_app, qa[j])});
            end
            erase(f_lock != 8'hc5 || !f_keep);
            apb(1'b1, 10'h028, 32'hc5);
            @(posedge clk);
            chk({31'h0, open_w}, 32'h1);
            erase(!f_keep);
            v = 8'($random(seed));
            if (v == 8'hc5) v = 8'h00;
            apb(1'b1, 10'h028, {24'h0, v});
            @(posedge clk);
            chk({31'h0, open_w}, 32'h0);
            erase(1'b1);
        end
        final_report;
    end
endmodule
`default_nettype wire
